// File: lstw_pkg.sv
// Package: shared types and constants for the list trigger-wait sequencer
package lstw_pkg;
  // Value and timing widths
  localparam int VAL_W = 16;
  localparam int CNT_W = 22;
  localparam int FLT_W = 16;
  localparam int CLK_MHZ = 100;
  // Filter times and timeout limit, in their own units
  localparam int HIGH_FILT_US = 400;
  localparam int LOW_FILT_US = 2;
  localparam int TMO_MAX_US = 33300;
  localparam logic [FLT_W-1:0] HIGH_FILT_CYC = FLT_W'(HIGH_FILT_US * CLK_MHZ);
  localparam logic [FLT_W-1:0] LOW_FILT_CYC = FLT_W'(LOW_FILT_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] TMO_MAX_CYC = CNT_W'(TMO_MAX_US * CLK_MHZ);
  // Error codes as posted to the error queue (two's complement)
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_CONFLICT = 16'hFF23;
  localparam logic [15:0] ERR_LEN = 16'hFF1E;
  localparam logic [15:0] ERR_UNBAL = 16'hFF14;
  localparam logic [VAL_W-1:0] VAL_RST = 16'h0000;

  // Trigger-wait step kinds
  typedef enum logic [1:0] {
    LSTW_WAIT_HIGH,
    LSTW_WAIT_LOW,
    LSTW_WAIT_FALL
  } lstw_kind_t;

  // One step request from the list controller
  typedef struct packed {
    lstw_kind_t kind;
    logic [VAL_W-1:0] value;
    logic [CNT_W-1:0] timeout;
  } lstw_step_t;

  // List consistency facts at step insertion
  typedef struct packed {
    logic has_value_list;
    logic [15:0] dwell_len;
    logic [15:0] value_len;
  } lstw_chk_t;
endpackage

// File: lstw_filter.sv
// Module: trigger level filter with selectable stability time
`timescale 1ns/100ps
module lstw_filter (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Raw level and stability time
  input wire logic raw,
  input wire logic [lstw_pkg::FLT_W-1:0] stable_cyc,
  // Filtered level
  output logic level_q
);
  logic [lstw_pkg::FLT_W-1:0] cnt_q;
  wire differs = (raw != level_q);
  wire settled = differs && (cnt_q + 1'b1 >= stable_cyc);

  // Count cycles the raw level disagrees; any bounce restarts the count
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
      level_q <= 1'b1;
    end else if (!differs || settled) begin
      cnt_q <= '0;
      level_q <= raw;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule

// File: lstw_checker.sv
// Module: list consistency checker producing error codes
`timescale 1ns/100ps
module lstw_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Step insertion
  input wire logic add,
  input wire lstw_pkg::lstw_kind_t kind,
  input wire lstw_pkg::lstw_chk_t chk,
  // Error report
  output logic err_q,
  output logic [15:0] code_q
);
  // Conflict is checked first since a missing list makes lengths meaningless
  wire no_list = !chk.has_value_list;
  wire mism = (chk.dwell_len != chk.value_len);
  wire is_low = (kind == lstw_pkg::LSTW_WAIT_LOW);
  wire [15:0] code_d = no_list ? lstw_pkg::ERR_CONFLICT :
                       (mism && is_low) ? lstw_pkg::ERR_UNBAL :
                       mism ? lstw_pkg::ERR_LEN : lstw_pkg::ERR_NONE;

  // One-cycle error pulse with its code held until the next insertion
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      err_q <= 1'b0;
      code_q <= lstw_pkg::ERR_NONE;
    end else begin
      err_q <= add && (code_d != lstw_pkg::ERR_NONE);
      if (add) begin
        code_q <= code_d;
      end
    end
  end
endmodule

// File: lstw_seq.sv
// Module: trigger-wait step sequencer for the output list
`timescale 1ns/100ps

//////////////////////////////////////////////////////////////////////////////
module lstw_seq (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // List control
  input wire logic list_clear,
  input wire logic step_start,
  input wire lstw_pkg::lstw_step_t step,
  // Step insertion checks
  input wire logic step_add,
  input wire lstw_pkg::lstw_chk_t add_chk,
  // Trigger pin
  input wire logic trig_in,
  // Outputs
  output logic [lstw_pkg::VAL_W-1:0] setpoint_q,
  output logic busy_q,
  output logic advance_q,
  output logic timed_out_q,
  output logic err_q,
  output logic [15:0] err_code_q
);
  typedef enum logic [1:0] {ST_IDLE, ST_EVAL, ST_WAIT} lstw_state_t;

  lstw_state_t state_q;
  lstw_pkg::lstw_kind_t kind_q;
  logic [lstw_pkg::CNT_W-1:0] tmo_q;
  logic [lstw_pkg::CNT_W-1:0] cnt_q;
  logic seen_high_q;
  logic raw_prev_q;
  logic hi_level;
  logic lo_level;

  ////////////////////////////////////////////////////////////////////////////
  // Two filters: the long one keeps high waits immune to glitches, the short
  // one lets low waits react in 2 us
  lstw_filter u_flt_hi (
    .clock(clock),
    .sys_rst(sys_rst),
    .raw(trig_in),
    .stable_cyc(lstw_pkg::HIGH_FILT_CYC),
    .level_q(hi_level)
  );
  lstw_filter u_flt_lo (
    .clock(clock),
    .sys_rst(sys_rst),
    .raw(trig_in),
    .stable_cyc(lstw_pkg::LOW_FILT_CYC),
    .level_q(lo_level)
  );

  lstw_checker u_chk (
    .clock(clock),
    .sys_rst(sys_rst),
    .add(step_add),
    .kind(step.kind),
    .chk(add_chk),
    .err_q(err_q),
    .code_q(err_code_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Condition decode
  wire starting = step_start && !list_clear;
  wire [lstw_pkg::CNT_W-1:0] tmo_d =
    (step.timeout > lstw_pkg::TMO_MAX_CYC) ? lstw_pkg::TMO_MAX_CYC : step.timeout;
  wire tmo_on = (tmo_q != '0);
  wire tmo_hit = tmo_on && (cnt_q >= tmo_q);
  // Raw edge: a pulse shorter than the 2 us filter is still seen here
  wire raw_fall = raw_prev_q && !trig_in;
  wire raw_rise = !raw_prev_q && trig_in;
  wire fall_hit = (seen_high_q || raw_prev_q) && raw_fall;
  wire high_hit = (kind_q == lstw_pkg::LSTW_WAIT_HIGH) && hi_level;
  wire low_hit = (kind_q == lstw_pkg::LSTW_WAIT_LOW) && !lo_level;
  wire edge_hit = (kind_q == lstw_pkg::LSTW_WAIT_FALL) && fall_hit;
  // Skip flag needs a timeout; eval_done also ends a zero-timeout step whose level is already met on entry
  wire skip = tmo_on && (high_hit || low_hit);
  // Zero timeout leaves only the trigger as a way out
  wire trig_done = high_hit || low_hit || edge_hit;
  wire eval_done = skip || (!tmo_on && (high_hit || low_hit)) || edge_hit;
  wire wait_done = trig_done || tmo_hit;
  wire done = (state_q == ST_EVAL) ? eval_done :
              (state_q == ST_WAIT) ? wait_done : 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  lstw_state_t state_d;
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (starting) begin
          state_d = ST_EVAL;
        end
      end
      ST_EVAL: begin
        state_d = eval_done ? ST_IDLE : ST_WAIT;
      end
      ST_WAIT: begin
        if (wait_done) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (list_clear) begin
      state_d = ST_IDLE;
    end
  end

  // State and step registers
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      kind_q <= lstw_pkg::LSTW_WAIT_HIGH;
      tmo_q <= '0;
    end else begin
      state_q <= state_d;
      if (starting && state_q == ST_IDLE) begin
        kind_q <= step.kind;
        tmo_q <= tmo_d;
      end
    end
  end

  // Setpoint is driven on acceptance, ahead of trigger evaluation
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      setpoint_q <= lstw_pkg::VAL_RST;
    end else if (list_clear) begin
      setpoint_q <= lstw_pkg::VAL_RST;
    end else if (starting && state_q == ST_IDLE) begin
      setpoint_q <= step.value;
    end
  end

  // Timeout counter runs only inside a step and clears on every advance
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else if (state_q == ST_IDLE || done || list_clear) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Edge history: a rise during the step sets seen_high_q; any raw fall ends the falling-edge wait, since raw_prev_q is high on every fall
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      raw_prev_q <= 1'b1;
      seen_high_q <= 1'b0;
    end else begin
      raw_prev_q <= trig_in;
      if (state_q == ST_IDLE || done) begin
        seen_high_q <= 1'b0;
      end else if (raw_rise) begin
        seen_high_q <= 1'b1;
      end
    end
  end

  // Status outputs
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
      advance_q <= 1'b0;
      timed_out_q <= 1'b0;
    end else begin
      busy_q <= (state_d != ST_IDLE);
      advance_q <= done && !list_clear;
      timed_out_q <= done && !list_clear && (state_q == ST_WAIT) && !trig_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_setpoint_load: assert property (@(posedge clock) disable iff (sys_rst)
    (starting && state_q == ST_IDLE) |=> setpoint_q == $past(step.value))
    else $error("setpoint not loaded at step start");
  a_skip_entry: assert property (@(posedge clock) disable iff (sys_rst)
    (state_q == ST_EVAL && skip && !list_clear) |=> advance_q)
    else $error("step not skipped");
  a_high_adv: assert property (@(posedge clock) disable iff (sys_rst)
    (state_q == ST_WAIT && high_hit && !list_clear) |=> advance_q && !timed_out_q)
    else $error("high wait did not advance");
  a_no_timeout_zero: assert property (@(posedge clock) disable iff (sys_rst)
    (!tmo_on) |=> !timed_out_q)
    else $error("timeout with zero wait");
  a_fall_needs_high: assert property (@(posedge clock) disable iff (sys_rst)
    (state_q == ST_WAIT && kind_q == lstw_pkg::LSTW_WAIT_FALL && !seen_high_q
     && !raw_prev_q && !tmo_hit) |=> !advance_q)
    else $error("falling wait advanced without high");
  a_edge_adv: assert property (@(posedge clock) disable iff (sys_rst)
    (state_q != ST_IDLE && edge_hit && !list_clear) |=> advance_q)
    else $error("falling edge missed");
  a_low_adv: assert property (@(posedge clock) disable iff (sys_rst)
    (state_q == ST_WAIT && low_hit && !list_clear) |=> advance_q)
    else $error("low wait did not advance");
  a_tmo_clamp: assert property (@(posedge clock) disable iff (sys_rst)
    tmo_q <= lstw_pkg::TMO_MAX_CYC)
    else $error("timeout above maximum");
  a_cnt_clear: assert property (@(posedge clock) disable iff (sys_rst)
    (advance_q) |-> cnt_q == '0)
    else $error("counter not cleared on advance");
  a_err_conflict: assert property (@(posedge clock) disable iff (sys_rst)
    (step_add && !add_chk.has_value_list) |=> err_q && err_code_q == lstw_pkg::ERR_CONFLICT)
    else $error("conflict error missing");
  a_err_unbal: assert property (@(posedge clock) disable iff (sys_rst)
    (step_add && add_chk.has_value_list && add_chk.dwell_len != add_chk.value_len
     && step.kind == lstw_pkg::LSTW_WAIT_LOW) |=> err_code_q == lstw_pkg::ERR_UNBAL)
    else $error("unbalanced error missing");
  a_err_len: assert property (@(posedge clock) disable iff (sys_rst)
    (step_add && add_chk.has_value_list && add_chk.dwell_len != add_chk.value_len
     && step.kind != lstw_pkg::LSTW_WAIT_LOW) |=> err_code_q == lstw_pkg::ERR_LEN)
    else $error("length error missing");

  c_timeout: cover property (@(posedge clock) timed_out_q);
  c_skip: cover property (@(posedge clock) state_q == ST_EVAL && skip);
  c_edge: cover property (@(posedge clock) state_q == ST_WAIT && edge_hit);
  c_err: cover property (@(posedge clock) err_q);
endmodule

// File: lstw_trig_host.sv
// Trigger source model standing for the host that drives the trigger pin
`timescale 1ns/100ps
module lstw_trig_host (
  // Clock
  input wire logic clock,
  // Trigger pin
  output logic trig_out
);
  // An open pin reads high, so the model idles high
  initial trig_out = 1'b1;
  // Levels change only just after an edge
  task automatic put_level(input logic v);
    @(posedge clock);
    trig_out <= v;
  endtask
  // Positive pulse, width in cycles
  task automatic pulse(input int w);
    put_level(1'b1);
    repeat (w) @(posedge clock);
    trig_out <= 1'b0;
  endtask
endmodule

// File: tb_list_step_trigger_wait.sv
// Testbench for the trigger-wait sequencer
`timescale 1ns/100ps
module tb_list_step_trigger_wait;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic list_clear = 1'b0;
  logic step_start = 1'b0;
  lstw_pkg::lstw_step_t step = '0;
  logic step_add = 1'b0;
  lstw_pkg::lstw_chk_t add_chk = '0;
  logic trig_in;
  logic [15:0] setpoint_q;
  logic busy_q, advance_q, timed_out_q, err_q;
  logic [15:0] err_code_q;
  logic [31:0] lfsr = 32'h0000_9e06;
  int error_cnt = 0;
  int n_tests = 0;
  int n;
  int hf;

  always #5 clock = ~clock;

  lstw_trig_host src (.clock(clock), .trig_out(trig_in));
  lstw_seq dut (.clock(clock), .sys_rst(sys_rst), .list_clear(list_clear),
    .step_start(step_start), .step(step), .step_add(step_add), .add_chk(add_chk),
    .trig_in(trig_in), .setpoint_q(setpoint_q), .busy_q(busy_q), .advance_q(advance_q),
    .timed_out_q(timed_out_q), .err_q(err_q), .err_code_q(err_code_q));

  //////////////////////////////////////////////////////////////////////////////
  // Random source and expectations
  function automatic logic [15:0] rnd16();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[15:0];
  endfunction
  // A missing value list outranks any length fault
  function automatic logic [15:0] exp_code(input logic [1:0] k, input logic has,
    input logic mis);
    if (!has) return 16'hff23;
    if (!mis) return 16'h0000;
    return (k == 2'd1) ? 16'hff14 : 16'hff1e;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Comparisons and verdict
  task automatic cmp_bit(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %b, seen %b", nm, e, g);
    end
  endtask
  task automatic cmp_word(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_cnt(input string nm, input int lo, input int hi, input int g);
    n_tests++;
    if (g < lo || g > hi) begin
      error_cnt++;
      $display("unexpected %s: expected %0d..%0d, seen %0d", nm, lo, hi, g);
    end
  endtask
  task automatic summarize;
    $display("checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Step driver: start, check entry, count cycles to advance (lim 0 skips it)
  task automatic run_step(input lstw_pkg::lstw_kind_t k, input logic [15:0] v,
    input int tmo, input int lim);
    @(posedge clock);
    step_start <= 1'b1;
    step <= '{k, v, 22'(tmo)};
    @(posedge clock);
    step_start <= 1'b0;
    #1;
    cmp_word("setpoint", v, setpoint_q);
    cmp_bit("busy", 1'b1, busy_q);
    n = 0;
    while (lim > 0 && advance_q !== 1'b1 && n < lim) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (lim > 0 && n >= lim) begin
      error_cnt++;
      $display("unexpected advance: wait ran out");
      summarize();
    end
  endtask
  // Insertion check with random list lengths
  task automatic add_step(input logic [1:0] k, input logic has, input logic mis);
    logic [15:0] d;
    logic [15:0] e;
    d = rnd16();
    e = exp_code(k, has, mis);
    @(posedge clock);
    step_add <= 1'b1;
    step.kind <= lstw_pkg::lstw_kind_t'(k);
    add_chk <= '{has, d, mis ? d + 16'h0001 : d};
    @(posedge clock);
    step_add <= 1'b0;
    #1;
    cmp_bit("error flag", e != 16'h0000, err_q);
    cmp_word("error code", e, err_code_q);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence; the high filter wait dominates run time
  initial begin
    hf = int'(lstw_pkg::HIGH_FILT_CYC);
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    run_step(lstw_pkg::LSTW_WAIT_HIGH, rnd16(), 1 + rnd16() % 500, 10);
    cmp_cnt("high skip delay", 1, 1, n);
    cmp_bit("skip timeout flag", 1'b0, timed_out_q);
    repeat (2) begin
      run_step(lstw_pkg::LSTW_WAIT_LOW, rnd16(), 50, 100);
      cmp_cnt("low timeout delay", 50, 54, n);
      cmp_bit("low timeout flag", 1'b1, timed_out_q);
    end
    fork
      run_step(lstw_pkg::LSTW_WAIT_LOW, rnd16(), 0, 1000);
      begin
        repeat (20) @(posedge clock);
        src.put_level(1'b0);
      end
    join
    cmp_cnt("low filter delay", 220, 228, n);
    cmp_bit("low level flag", 1'b0, timed_out_q);
    run_step(lstw_pkg::LSTW_WAIT_LOW, rnd16(), 1 + rnd16() % 500, 10);
    cmp_cnt("low skip delay", 1, 1, n);
    fork
      run_step(lstw_pkg::LSTW_WAIT_FALL, rnd16(), 0, 1000);
      begin
        repeat (300) @(posedge clock);
        src.pulse(1);
      end
    join
    cmp_cnt("edge delay", 301, 310, n);
    run_step(lstw_pkg::LSTW_WAIT_FALL, rnd16(), 40, 100);
    cmp_cnt("edge timeout delay", 40, 44, n);
    cmp_bit("edge timeout flag", 1'b1, timed_out_q);
    // The pin has been low only briefly; let the long filter settle low first,
    // otherwise a zero-timeout high wait would find the level already high
    repeat (hf + 100) @(posedge clock);
    // Zero timeout holds, then a clear aborts it
    run_step(lstw_pkg::LSTW_WAIT_HIGH, rnd16(), 0, 0);
    repeat (100) @(posedge clock);
    #1;
    cmp_bit("busy while held", 1'b1, busy_q);
    @(posedge clock);
    list_clear <= 1'b1;
    @(posedge clock);
    list_clear <= 1'b0;
    #1;
    cmp_bit("busy after clear", 1'b0, busy_q);
    cmp_word("setpoint after clear", 16'h0000, setpoint_q);
    for (int i = 0; i < 9; i++) begin
      add_step(2'(i % 3), i >= 3, i < 3 || i >= 6);
    end
    run_step(lstw_pkg::LSTW_WAIT_HIGH, rnd16(), 100, 200);
    cmp_cnt("high timeout delay", 100, 104, n);
    cmp_bit("high timeout flag", 1'b1, timed_out_q);
    fork
      run_step(lstw_pkg::LSTW_WAIT_HIGH, rnd16(), 0, hf + 1000);
      begin
        repeat (20) @(posedge clock);
        src.put_level(1'b1);
      end
    join
    cmp_cnt("high filter delay", hf + 20, hf + 28, n);
    summarize();
  end
endmodule
